/* hdl/pse_class_report_regs.sv */
// Class report bytes for channels 2 to 4 and auto-class control for four channels
`include "pcr_map.svh"
module pse_class_report_regs #(
  parameter int NCH = 4  // Channels served by the control byte
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Command port from the serial command engine
  input  wire logic                 cmd_valid,
  input  wire logic                 cmd_write,
  input  wire logic [7:0]           cmd_code,
  input  wire logic [7:0]           cmd_wdata,
  output logic                      rsp_valid,
  output logic [7:0]                rsp_rdata,
  // Channel status from the port controller
  input  wire logic [NCH-1:0]       chan_on,
  input  wire logic [NCH-1:0]       class_done,
  input  wire logic [NCH-1:0]       class_measured,
  input  wire logic [NCH-1:0][3:0]  powered_class,
  input  wire logic [NCH-1:0][3:0]  alloc_class,
  input  wire logic [NCH-1:0]       four_pair_ss,
  input  wire logic [NCH-1:0]       dual_sig,
  input  wire logic [NCH-1:0]       class0_sig,
  input  wire logic [NCH-1:0]       manual_mode,
  input  wire logic [NCH-1:0]       alloc_is_15w4,
  input  wire logic [NCH-1:0]       one_finger,
  input  wire logic [NCH-1:0]       semi_auto,
  input  wire logic [NCH-1:0]       detection_enable,
  input  wire logic [NCH-1:0]       class_enable,
  input  wire logic [NCH-1:0][3:0]  prev3_class,
  input  wire logic [NCH-1:0]       ac_result_updated,
  // Results to the event register and power-cut logic
  output logic [NCH-1:0]            classification_complete_flag,
  output logic [NCH-1:0]            ac_start,
  output logic [NCH-1:0]            autoadjust_enable
);

  //////////////////////////////////////////////////////////////////
  // Declarations

  logic [NCH-1:0]            manual_measure_request; // Request bits
  logic [NCH-1:0]            mreq_d;       // Next request bits
  logic [NCH-1:0]            aadj_d;       // Next enable bits
  logic [NCH-1:0]            on_q;         // Channel on, last cycle
  logic [NCH-1:0]            turn_on;      // Channel turning on
  logic [NCH-1:0]            start_now;    // Launch a measurement
  logic [NCH-1:0]            hw_clear;     // Hardware clears request
  logic [NCH-1:0]            wr_set;       // Host writes request 1
  logic [NCH-1:0][3:0]       own_code;     // Own assigned code
  logic [NCH-1:0][3:0]       prev_code;    // Own previous code
  logic [NCH-1:0]            slot_upd;     // Load the report slot
  logic [NCH-1:0][3:0]       slot_acode;   // Assigned code to load
  logic [NCH-1:0][3:0]       slot_pcode;   // Previous code to load
  logic [7:0]                report [NCH]; // Report bytes
  pcr_pkg::pcr_ac_state_t    ac_q [NCH];   // Measurement state
  pcr_pkg::pcr_ac_state_t    ac_d [NCH];   // Next measurement state
  logic                      rd_cmd;       // Read request
  logic                      wr_ctrl;      // Write to control byte
  logic [7:0]                ctrl_byte;    // Control byte view
  logic [7:0]                rd_byte;      // Selected read data

  //////////////////////////////////////////////////////////////////
  // Command decode

  assign rd_cmd    = cmd_valid && !cmd_write;
  assign wr_ctrl   = cmd_valid && cmd_write &&
                     cmd_code == `PCR_CMD_AC_CTRL;
  assign ctrl_byte = {manual_measure_request, autoadjust_enable};
  assign wr_set    = wr_ctrl ? cmd_wdata[`PCR_MREQ_LSB +: NCH]
                             : '0;

  // Read mux; unmapped codes read zero
  assign rd_byte =
    (cmd_code == `PCR_CMD_CH2_CLASS) ? report[1] :
    (cmd_code == `PCR_CMD_CH3_CLASS) ? report[2] :
    (cmd_code == `PCR_CMD_CH4_CLASS) ? report[3] :
    (cmd_code == `PCR_CMD_AC_CTRL)   ? ctrl_byte :
                                       `PCR_RESET_BYTE;

  // Read answer one cycle after the request
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= `PCR_RESET_BYTE;
    end else begin
      rsp_valid <= rd_cmd;
      rsp_rdata <= rd_cmd ? rd_byte : rsp_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Auto-class control byte

  // Turn-on edge and hardware clears of the request bits
  assign turn_on  = chan_on & ~on_q;
  assign hw_clear = ac_result_updated | turn_on;

  // Host write wins over a clear in the same cycle
  assign mreq_d = wr_ctrl ? cmd_wdata[`PCR_MREQ_LSB +: NCH]
                          : manual_measure_request & ~hw_clear;
  assign aadj_d = wr_ctrl ? cmd_wdata[`PCR_AADJ_LSB +: NCH]
                          : autoadjust_enable;

  // Control byte storage; enables go straight to power-cut logic
  always_ff @(posedge clk) begin
    if (reset) begin
      manual_measure_request <= '0;
      autoadjust_enable      <= '0;
      on_q                   <= '0;
    end else begin
      manual_measure_request <= mreq_d;
      autoadjust_enable      <= aadj_d;
      on_q                   <= chan_on;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Manual measurement launch

  // Only an on channel with a pending request starts
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      start_now[i] = 1'b0;
      ac_d[i]      = ac_q[i];
      case (ac_q[i])
        pcr_pkg::PCR_AC_IDLE: begin
          if (chan_on[i] && on_q[i] && manual_measure_request[i] &&
              !hw_clear[i]) begin
            start_now[i] = 1'b1;
            ac_d[i]      = pcr_pkg::PCR_AC_BUSY;
          end
        end
        pcr_pkg::PCR_AC_BUSY: begin
          if (ac_result_updated[i] || !chan_on[i]) begin
            ac_d[i] = pcr_pkg::PCR_AC_IDLE;
          end
        end
        default: ac_d[i] = pcr_pkg::PCR_AC_IDLE;
      endcase
    end
  end

  // Measurement state and start pulses
  always_ff @(posedge clk) begin
    for (int i = 0; i < NCH; i++) begin
      ac_q[i] <= reset ? pcr_pkg::PCR_AC_IDLE : ac_d[i];
    end
    ac_start <= reset ? '0 : start_now;
  end

  //////////////////////////////////////////////////////////////////
  // Classification complete flag

  // Flag only the channel that really measured
  always_ff @(posedge clk) begin
    if (reset) begin
      classification_complete_flag <= '0;
    end else begin
      classification_complete_flag <= class_done & class_measured;
    end
  end

  //////////////////////////////////////////////////////////////////
  // Class codes and report slots

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    localparam int P = i ^ 1; // Partner channel of the port
    logic [3:0] eff_cls;  // Class after class-zero promotion
    logic [3:0] lim_cls;  // Class after allocation limit
    logic       prev_ok;  // Previous result may be kept
    logic       copy;     // Take the partner's result

    // Class zero powers as class three
    assign eff_cls = class0_sig[i] ? `PCR_CLASS_3 : powered_class[i];
    // Allocation caps the class requested kept apart
    assign lim_cls = (eff_cls > alloc_class[i]) ? alloc_class[i]
                                                : eff_cls;
    // Manual mode gives no assigned class code
    assign own_code[i] = manual_mode[i] ? `PCR_CODE_UNKNOWN :
      pcr_pkg::pcr_encode(lim_cls, four_pair_ss[i], dual_sig[i],
                          1'b0);
    // Three-finger result kept only when all hold
    assign prev_ok = alloc_is_15w4[i] & one_finger[i] &
                     semi_auto[i] & detection_enable[i] &
                     class_enable[i];
    assign prev_code[i] = prev_ok ?
      pcr_pkg::pcr_encode(prev3_class[i], four_pair_ss[i],
                          dual_sig[i], 1'b1)
      : `PCR_CODE_UNKNOWN;
    // Single signature mirrors into the partner
    assign copy = class_done[P] & four_pair_ss[P] & ~class_done[i];
    // Dual signature loads its own result only
    assign slot_upd[i]   = chan_on[i] & (class_done[i] | copy);
    assign slot_acode[i] = copy ? own_code[P] : own_code[i];
    assign slot_pcode[i] = copy ? prev_code[P] : prev_code[i];

    if (i == 0) begin : g_noslot
      assign report[i] = `PCR_RESET_BYTE;
    end else begin : g_slot
      pcr_slot_if u_if ();
      assign u_if.update        = slot_upd[i];
      assign u_if.clear         = ~chan_on[i];
      assign u_if.assigned_code = slot_acode[i];
      assign u_if.previous_code = slot_pcode[i];
      assign report[i]          = u_if.report;
      pcr_class_slot u_slot (
        .clk   (clk),
        .reset (reset),
        .sl    (u_if.slot)
      );
    end
  end

  //////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_read_cmd;
    rd_cmd;
  endsequence

  sequence s_ctrl_read;
    rd_cmd && cmd_code == `PCR_CMD_AC_CTRL;
  endsequence

  property p_read_answer;
    s_read_cmd |=> rsp_valid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered in one cycle");

  property p_ctrl_read;
    s_ctrl_read |=> rsp_rdata == $past(ctrl_byte);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control byte read back wrong");

  property p_aadj_write;
    wr_ctrl |=> autoadjust_enable == $past(cmd_wdata[3:0]);
  endproperty
  a_aadj_write: assert property (p_aadj_write)
    else $error("auto-adjust enables not written");

  property p_flag_measured;
    1'b1 |=> classification_complete_flag ==
             $past(class_done & class_measured);
  endproperty
  a_flag_measured: assert property (p_flag_measured)
    else $error("complete flag on unmeasured channel");

  property p_start_on;
    (ac_start & ~$past(chan_on)) == '0;
  endproperty
  a_start_on: assert property (p_start_on)
    else $error("measurement started on an off channel");

  property p_result_clears;
    |(ac_result_updated & ~wr_set) |=>
      (manual_measure_request & $past(ac_result_updated & ~wr_set))
      == '0;
  endproperty
  a_result_clears: assert property (p_result_clears)
    else $error("request bit not cleared after result");

  property p_turnon_clears;
    |(turn_on & ~wr_set) |=>
      (manual_measure_request & $past(turn_on & ~wr_set)) == '0;
  endproperty
  a_turnon_clears: assert property (p_turnon_clears)
    else $error("early request survived turn-on");

  property p_start_prompt;
    |start_now ##1 1'b1 |-> ac_start == $past(start_now) ##1
      (ac_start & $past(ac_start, 2)) == '0;
  endproperty
  a_start_prompt: assert property (p_start_prompt)
    else $error("start pulse late or repeated");

  property p_manual_unknown;
    slot_upd[1] && manual_mode[1] && !(class_done[0] &&
      four_pair_ss[0] && !class_done[1]) && chan_on[1] |=>
      report[1][7:4] == `PCR_CODE_UNKNOWN;
  endproperty
  a_manual_unknown: assert property (p_manual_unknown)
    else $error("manual mode channel got a class");

endmodule

/* hdl/pcr_map.svh */
// Command codes, field positions, reset values and class codes
// How it works
// - Channels 2 to 4 read-only class bytes
// - Channel turn-off clears both class nibbles
// - Assigned nibble uses the documented class codes
// - Previous nibble adds code six for class0
// - Single-signature port shows class on both channels; the channel 1-2 port shows it on channel 2 only
// - Complete flag only on measured channel
// - Dual-signature channels report their own class
// - Class zero signature is reported as three
// - Manual mode channels report no assigned class; a class mirrored from a single-signature partner still loads
// - Assigned class limited by allocation setting
// - Requested class kept apart from assigned class
// - Store three-finger result under listed conditions
// - Auto-class control byte, requests and enables
// - Manual request starts measurement within bound
// - Request bit cleared after result update
// - Requests set before turn-on cleared
// - Auto-adjust enable steers power-cut adjustment
`ifndef PCR_MAP_SVH
`define PCR_MAP_SVH
`define PCR_CMD_CH2_CLASS    8'h4d
`define PCR_CMD_CH3_CLASS    8'h4e
`define PCR_CMD_CH4_CLASS    8'h4f
`define PCR_CMD_AC_CTRL      8'h50
`define PCR_RESET_BYTE       8'h00
`define PCR_MREQ_LSB         4
`define PCR_AADJ_LSB         0
`define PCR_CODE_UNKNOWN     4'h0
`define PCR_CODE_PREV_CLASS0 4'h6
`define PCR_CODE_DUAL_5      4'hd
`define PCR_CLASS_3          4'h3
`define PCR_CLASS_MAX_2PAIR  4'h4
`define PCR_CLASS_MAX        4'h8
`define PCR_CLASS_DUAL_MAX   4'h5
`define PCR_SS_OFFSET        4'h3
`endif

/* hdl/pcr_pkg.sv */
// Types and class code helpers shared by the reporting block
`include "pcr_map.svh"
package pcr_pkg;

  // Per-channel auto-class measurement state
  typedef enum logic [1:0] {
    PCR_AC_IDLE = 2'b00,
    PCR_AC_BUSY = 2'b01
  } pcr_ac_state_t;

  // One class nibble
  typedef logic [3:0] pcr_code_t;

  // Class number to nibble code; prev selects the previous table
  function automatic pcr_code_t pcr_encode(input logic [3:0] num,
                                           input logic       ss,
                                           input logic       dual,
                                           input logic       prev);
    pcr_code_t c;
    c = `PCR_CODE_UNKNOWN;
    if (num == 4'h0) begin
      c = prev ? `PCR_CODE_PREV_CLASS0 : `PCR_CODE_UNKNOWN;
    end else if (num <= `PCR_CLASS_MAX_2PAIR) begin
      c = num;
    end else if (ss && num <= `PCR_CLASS_MAX) begin
      c = num + `PCR_SS_OFFSET;
    end else if (dual && num == `PCR_CLASS_DUAL_MAX) begin
      c = `PCR_CODE_DUAL_5;
    end
    return c;
  endfunction

  // True for a code that may be stored in the given nibble
  function automatic logic pcr_legal(input pcr_code_t c,
                                     input logic      prev);
    logic ok;
    ok = 1'b0;
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4: ok = 1'b1;
      4'h8, 4'h9, 4'ha, 4'hb, 4'hd: ok = 1'b1;
      4'h6:                         ok = prev;
      default:                      ok = 1'b0;
    endcase
    return ok;
  endfunction

endpackage

/* hdl/pcr_slot_if.sv */
// Link between the controller and one class report slot
interface pcr_slot_if;
  logic       update;         // Load new codes
  logic       clear;          // Channel is off
  logic [3:0] assigned_code;  // Assigned nibble to load
  logic [3:0] previous_code;  // Previous nibble to load
  logic [7:0] report;         // Stored report byte

  modport ctrl (output update, clear, assigned_code, previous_code,
                input  report);
  modport slot (input  update, clear, assigned_code, previous_code,
                output report);
endinterface

/* hdl/pcr_class_slot.sv */
// One read-only class report byte with reserved-code filtering
`include "pcr_map.svh"
module pcr_class_slot (
  input wire logic clk,
  input wire logic reset,
  pcr_slot_if.slot sl
);

  logic [7:0] report_q;  // Stored report byte
  logic       a_ok;      // Assigned code is legal
  logic       p_ok;      // Previous code is legal
  logic [7:0] load_byte; // Filtered byte to load

  // Reserved codes collapse to unknown
  assign a_ok      = pcr_pkg::pcr_legal(sl.assigned_code, 1'b0);
  assign p_ok      = pcr_pkg::pcr_legal(sl.previous_code, 1'b1);
  assign load_byte = {a_ok ? sl.assigned_code : `PCR_CODE_UNKNOWN,
                      p_ok ? sl.previous_code : `PCR_CODE_UNKNOWN};
  assign sl.report = report_q;

  // Off channel clears, else load on update
  always_ff @(posedge clk) begin
    if (reset || sl.clear) begin
      report_q <= `PCR_RESET_BYTE;
    end else if (sl.update) begin
      report_q <= load_byte;
    end
  end

  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_slot_clear;
    sl.clear |=> report_q == `PCR_RESET_BYTE;
  endproperty
  a_slot_clear: assert property (p_slot_clear)
    else $error("class byte not cleared when channel off");

  property p_slot_legal;
    pcr_pkg::pcr_legal(report_q[7:4], 1'b0) &&
    pcr_pkg::pcr_legal(report_q[3:0], 1'b1);
  endproperty
  a_slot_legal: assert property (p_slot_legal)
    else $error("reserved class code stored");

  property p_slot_load;
    sl.update && !sl.clear |=> report_q == $past(load_byte);
  endproperty
  a_slot_load: assert property (p_slot_load)
    else $error("class byte not loaded on update");

endmodule

/* testbench/pcr_host_model.sv */
// Host model: issues single-byte commands on the command port
module pcr_host_model (
  input  wire logic       clk,
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic [7:0]      cmd_code,
  output logic [7:0]      cmd_wdata,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle command port from time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // One command, raised after an edge and held through the taking edge
  task automatic issue(input logic wr, input logic [7:0] code,
                       input logic [7:0] wdata);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code  <= code;
    cmd_wdata <= wdata;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~wdata;  // Stale data is not left on the port
  endtask

  // Write one byte; writes get no answer
  task automatic write_byte(input logic [7:0] code, input logic [7:0] data);
    issue(1'b1, code, data);
  endtask

  // Read one byte; the answer is awaited for at most three cycles
  task automatic read_byte(input logic [7:0] code, output logic [7:0] data);
    logic got;
    got  = 1'b0;
    data = 8'hxx;
    issue(1'b0, code, 8'h00);
    for (int i = 0; i < 3 && !got; i++) begin
      #1;
      if (rsp_valid === 1'b1) begin
        data = rsp_rdata;
        got  = 1'b1;
      end else begin
        @(posedge clk);
      end
    end
  endtask
endmodule

/* testbench/tb_pse_class_report_regs.sv */
// Self-checking bench for the class report and auto-class control block
module tb_pse_class_report_regs;
  timeunit 1ns;
  timeprecision 100ps;

  logic            clk;                           // 125 MHz clock
  logic            reset;                         // Synchronous reset
  logic            cmd_valid, cmd_write;          // Command strobe, kind
  logic [7:0]      cmd_code, cmd_wdata;           // Command code, data
  logic            rsp_valid;                     // Read answer strobe
  logic [7:0]      rsp_rdata;                     // Read answer byte
  logic [3:0]      chan_on, class_done, class_measured;
  logic [3:0]      four_pair_ss, dual_sig, class0_sig, manual_mode;
  logic [3:0]      alloc_is_15w4, one_finger, semi_auto;
  logic [3:0]      detection_enable, class_enable, ac_result_updated;
  logic [3:0][3:0] powered_class, alloc_class, prev3_class;
  logic [3:0]      classification_complete_flag;  // Event flags
  logic [3:0]      ac_start;                      // Measurement launch
  logic [3:0]      autoadjust_enable;             // Control bits 3..0
  int              fails = 0;                     // Mismatch count
  int              n_compared = 0;                // Comparison count
  int              cycles = 0;                    // Run length so far
  localparam int   MAX_CYCLES = 3000;             // Hang ceiling

  // Device under test
  pse_class_report_regs #(.NCH(4)) i_dut (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .chan_on(chan_on),
    .class_done(class_done), .class_measured(class_measured),
    .powered_class(powered_class), .alloc_class(alloc_class),
    .four_pair_ss(four_pair_ss), .dual_sig(dual_sig),
    .class0_sig(class0_sig), .manual_mode(manual_mode),
    .alloc_is_15w4(alloc_is_15w4), .one_finger(one_finger),
    .semi_auto(semi_auto), .detection_enable(detection_enable),
    .class_enable(class_enable), .prev3_class(prev3_class),
    .ac_result_updated(ac_result_updated),
    .classification_complete_flag(classification_complete_flag),
    .ac_start(ac_start), .autoadjust_enable(autoadjust_enable)
  );

  // Host on the command port
  pcr_host_model i_host (
    .clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // Clock generator
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Cuts a hung run short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      fails = fails + 1;
      $display("unexpected at %0t: run timed out", $time);
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compare a byte
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask

  // Compare a per-channel vector
  task automatic chk4(input logic [3:0] got, input logic [3:0] exp,
                      input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s %b not %b", $time, what, got, exp);
    end
  endtask

  // Read a register and compare it
  task automatic rd_chk(input logic [7:0] code, input logic [7:0] exp,
                        input string what);
    logic [7:0] d;
    i_host.read_byte(code, d);
    chk8(d, exp, what);
  endtask

  // Pulse classification done; the flag follows one cycle later
  task automatic pulse_done(input logic [3:0] done, input logic [3:0] meas);
    @(posedge clk);
    class_done     <= done;
    class_measured <= meas;
    @(posedge clk);
    class_done     <= 4'h0;
    class_measured <= 4'h0;
    #1;
    chk4(classification_complete_flag, done & meas, "flag");
  endtask

  // Load one channel and read its report byte back
  task automatic done_chk(input int ch, input logic [7:0] exp,
                          input string what);
    pulse_done(4'(1 << ch), 4'(1 << ch));
    rd_chk(8'(ch + 8'h4c), exp, what);
  endtask

  // Expected assigned nibble, four-pair single-signature device
  function automatic logic [3:0] enc(input logic [3:0] n);
    if (n <= 4'h4) return n;
    if (n <= 4'h8) return n + 4'h3;
    return 4'h0;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped read, write to a read-only byte
  task automatic t_reset_values();
    rd_chk(8'h4d, 8'h00, "ch2");
    rd_chk(8'h4e, 8'h00, "ch3");
    rd_chk(8'h4f, 8'h00, "ch4");
    rd_chk(8'h50, 8'h00, "control");
    rd_chk(8'h4c, 8'h00, "unmapped");
    i_host.write_byte(8'h4e, 8'hff);
    rd_chk(8'h4e, 8'h00, "ch3 written");
    chk4(autoadjust_enable, 4'h0, "aadj");
  endtask

  // Every class number on a single-signature port
  task automatic t_class_codes();
    logic [3:0] e;
    chan_on      <= 4'hf;
    four_pair_ss <= 4'b1100;
    alloc_class  <= {4{4'h8}};
    for (int n = 0; n <= 8; n++) begin
      powered_class[2] <= n[3:0];
      pulse_done(4'b0100, 4'b0100);
      e = enc(n[3:0]);
      rd_chk(8'h4e, {e, 4'h0}, "ch3");
      rd_chk(8'h4f, {e, 4'h0}, "ch4 copy");
    end
  endtask

  // Dual signature, reserved class, class zero, cap and manual mode
  task automatic t_dual_and_limits();
    four_pair_ss     <= 4'h0;
    dual_sig         <= 4'b1100;
    powered_class[2] <= 4'h5;
    powered_class[3] <= 4'h3;
    pulse_done(4'b1100, 4'b1100);
    rd_chk(8'h4e, 8'hd0, "ch3 dual");
    rd_chk(8'h4f, 8'h30, "ch4 dual");
    powered_class[1] <= 4'h6;
    done_chk(1, 8'h00, "no signature");
    powered_class[1] <= 4'h0;
    class0_sig[1]    <= 1'b1;
    done_chk(1, 8'h30, "class zero");
    class0_sig[1]    <= 1'b0;
    powered_class[1] <= 4'h4;
    alloc_class[1]   <= 4'h2;
    done_chk(1, 8'h20, "capped");
    manual_mode[1]   <= 1'b1;
    done_chk(1, 8'h00, "manual");
    manual_mode[1]   <= 1'b0;
  endtask

  // Previous three-finger result kept only under its conditions
  task automatic t_previous();
    alloc_class[1]   <= 4'h8;
    powered_class[1] <= 4'h2;
    alloc_is_15w4[1] <= 1'b1;
    one_finger[1]    <= 1'b1;
    semi_auto[1]     <= 1'b1;
    detection_enable[1] <= 1'b1;
    class_enable[1]  <= 1'b1;
    prev3_class[1]   <= 4'h0;
    done_chk(1, 8'h26, "prev class0");
    prev3_class[1]   <= 4'h4;
    done_chk(1, 8'h24, "prev class4");
    one_finger[1]    <= 1'b0;
    done_chk(1, 8'h20, "prev dropped");
  endtask

  // Turn-off clears the byte, loads while off are ignored
  task automatic t_turn_off();
    chan_on[2] <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(8'h4e, 8'h00, "ch3 off");
    powered_class[2] <= 4'h1;
    pulse_done(4'b0100, 4'b0000);
    rd_chk(8'h4e, 8'h00, "ch3 off load");
  endtask

  // Manual measurement requests and auto-adjust enables
  task automatic t_manual();
    logic [3:0] starts;
    starts = 4'h0;
    i_host.write_byte(8'h50, 8'h55);
    repeat (3) begin
      @(posedge clk);
      #1;
      starts |= ac_start;
    end
    chk4(starts, 4'b0001, "start");
    chk4(autoadjust_enable, 4'h5, "aadj");
    rd_chk(8'h50, 8'h55, "control");
    @(posedge clk);
    ac_result_updated <= 4'h1;
    @(posedge clk);
    ac_result_updated <= 4'h0;
    rd_chk(8'h50, 8'h45, "request done");
    chan_on[2] <= 1'b1;
    starts = 4'h0;
    repeat (3) begin
      @(posedge clk);
      #1;
      starts |= ac_start;
    end
    chk4(starts, 4'h0, "start at turn-on");
    rd_chk(8'h50, 8'h05, "request at turn-on");
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    {chan_on, class_done, class_measured, four_pair_ss, dual_sig} = '0;
    {class0_sig, manual_mode, alloc_is_15w4, one_finger, semi_auto} = '0;
    {detection_enable, class_enable, ac_result_updated} = '0;
    {powered_class, alloc_class, prev3_class} = '0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset_values();
    t_class_codes();
    t_dual_and_limits();
    t_previous();
    t_turn_off();
    t_manual();
    complete_run();
  end
endmodule
